// ==== core/sop_pkg.sv ====
package sop_pkg;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int RX_MIN_NS = 30000;
  localparam int TX_PULSE_NS = 40000;
  // Least times round up to whole cycles
  localparam int RX_MIN_CYC = (RX_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TX_CYC = (TX_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W = 10;
  localparam int PWM_W = 16;
  localparam logic [CNT_W-1:0] RX_LAST = CNT_W'(RX_MIN_CYC - 1);
  localparam logic [CNT_W-1:0] TX_LAST = CNT_W'(TX_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
  localparam logic [PWM_W-1:0] PWM_ZERO = 16'h0000;
  localparam logic [PWM_W-1:0] PWM_ONE = 16'h0001;
  localparam logic [PWM_W-1:0] PWM_PERIOD_RST = 16'h03e8;
  localparam logic [PWM_W-1:0] PWM_HIGH_RST = 16'h01f4;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [1:0] {
    MODE_SYNC = 2'h0,
    MODE_INPUT = 2'h1,
    MODE_LEVEL = 2'h2,
    MODE_PWM = 2'h3
  } sop_mode_t;

  typedef enum logic [1:0] {
    SY_IDLE = 2'h0,
    SY_TX = 2'h1,
    SY_WAIT = 2'h3
  } sop_sm_t;

  typedef struct packed {
    sop_mode_t mode;
    logic invert;
    logic level;
    logic [PWM_W-1:0] pwmPeriod;
    logic [PWM_W-1:0] pwmHigh;
  } sop_cfg_t;

  typedef struct packed {
    sop_cfg_t cfg;
    logic [2:0] syn;
    logic stable;
    sop_sm_t sm;
    logic [CNT_W-1:0] rxCnt;
    logic [CNT_W-1:0] txCnt;
    logic [PWM_W-1:0] pwmCnt;
    logic outOn;
    logic pinO;
    logic pinOe;
    logic levelIn;
    logic syncRx;
  } sop_state_t;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam sop_cfg_t CFG_RST = '{
    mode: MODE_SYNC,
    invert: 1'b0,
    level: 1'b0,
    pwmPeriod: PWM_PERIOD_RST,
    pwmHigh: PWM_HIGH_RST
  };
  localparam logic [2:0] SYN_RST = 3'h7;
  localparam logic IDLE_LVL = 1'b1;
  localparam sop_state_t ST_RST = '{
    cfg: CFG_RST,
    syn: SYN_RST,
    stable: IDLE_LVL,
    sm: SY_IDLE,
    rxCnt: CNT_ZERO,
    txCnt: CNT_ZERO,
    pwmCnt: PWM_ZERO,
    outOn: 1'b0,
    pinO: IDLE_LVL,
    pinOe: 1'b0,
    levelIn: IDLE_LVL,
    syncRx: 1'b0
  };

endpackage

// ==== core/sop_sync_off_io_pin.sv ====
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Invert setting flips every level or pulse sent or received.
// - Level output 1 drives low, or high when inverted.
// - Level output 0 drives high, or low when inverted.
// - PWM output uses separate frequency and duty settings.
// - Input function samples the pin as an external level.
// - Sync turn-off is the default function after config reset.
// - Output going from on to off emits a sync pulse.
// - Sync pulse received while off leaves output off.
// - Sync pulse received while on turns output off.
// - Sync pulse holds active level at least 30 us.
// - One instrument switching off turns the partner off too.
module sop_sync_off_io_pin
  import sop_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic cfgWr,
  input wire sop_cfg_t cfgIn,
  input wire logic onReq,
  input wire logic offReq,
  input wire logic pinI,
  output logic pinO,
  output logic pinOe,
  output logic outputOn,
  output logic levelIn,
  output logic syncRx
);

  // ***************************************************************
  // State
  // ***************************************************************
  sop_state_t st_q;
  sop_state_t st_d;
  logic isSync;
  logic rxActive;
  logic rxHit;
  logic offEdge;
  logic pwmLvl;
  logic lvlOne;
  logic lvlZero;
  logic pwmRun;
  logic inRun;
  logic txTrig;
  logic hitOn;
  logic hitOff;

  assign isSync = (st_q.cfg.mode == MODE_SYNC);
  assign rxActive = ~(st_q.stable ^ st_q.cfg.invert);
  assign rxHit = isSync && (st_q.sm == SY_IDLE) && rxActive &&
                 (st_q.rxCnt == RX_LAST);
  assign pwmLvl = (st_q.pwmCnt < st_q.cfg.pwmHigh);

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    st_d = st_q;
    if (cfgWr) begin
      st_d.cfg = cfgIn;
    end

    st_d.syn = {st_q.syn[1:0], pinI};
    if (st_q.syn[1] == st_q.syn[2]) begin
      st_d.stable = st_q.syn[2];
    end
    st_d.levelIn = st_q.stable ^ st_q.cfg.invert;

    // Once on, a repeated on request changes nothing
    if (st_q.outOn) begin
      if (offReq || rxHit) begin
        st_d.outOn = 1'b0;
      end
    end else if (onReq) begin
      st_d.outOn = 1'b1;
    end
    offEdge = st_q.outOn && !st_d.outOn;
    st_d.syncRx = rxHit;

    if (!isSync) begin
      st_d.sm = SY_IDLE;
      st_d.rxCnt = CNT_ZERO;
      st_d.txCnt = CNT_ZERO;
    end else if (offEdge && (st_q.sm != SY_TX)) begin
      st_d.sm = SY_TX;
      st_d.txCnt = TX_LAST;
      st_d.rxCnt = CNT_ZERO;
    end else begin
      unique case (st_q.sm)
        SY_IDLE: begin
          if (rxHit) begin
            st_d.sm = SY_WAIT;
            st_d.rxCnt = CNT_ZERO;
          end else if (rxActive) begin
            st_d.rxCnt = st_q.rxCnt + CNT_ONE;
          end else begin
            st_d.rxCnt = CNT_ZERO;
          end
        end
        SY_TX: begin
          if (st_q.txCnt == CNT_ZERO) begin
            st_d.sm = SY_WAIT;
          end else begin
            st_d.txCnt = st_q.txCnt - CNT_ONE;
          end
        end
        SY_WAIT: begin
          if (!rxActive) begin
            st_d.sm = SY_IDLE;
          end
        end
        default: begin
          st_d.sm = SY_IDLE;
        end
      endcase
    end

    // ***************************************************************
    // PWM counter
    // ***************************************************************
    // A zero period parks the counter; duty then decides the level
    if ((st_q.cfg.mode != MODE_PWM) || (st_q.cfg.pwmPeriod == PWM_ZERO)) begin
      st_d.pwmCnt = PWM_ZERO;
    end else if (st_q.pwmCnt >= (st_q.cfg.pwmPeriod - PWM_ONE)) begin
      st_d.pwmCnt = PWM_ZERO;
    end else begin
      st_d.pwmCnt = st_q.pwmCnt + PWM_ONE;
    end

    // ***************************************************************
    // Pin drive
    // ***************************************************************
    unique case (st_q.cfg.mode)
      MODE_SYNC: begin
        // Released between pulses so the partner can pull the line
        st_d.pinOe = (st_d.sm == SY_TX);
        st_d.pinO = st_d.pinOe ? st_q.cfg.invert : ~st_q.cfg.invert;
      end
      MODE_INPUT: begin
        st_d.pinOe = 1'b0;
        st_d.pinO = ~st_q.cfg.invert;
      end
      MODE_LEVEL: begin
        st_d.pinOe = 1'b1;
        st_d.pinO = ~st_q.cfg.level ^ st_q.cfg.invert;
      end
      MODE_PWM: begin
        st_d.pinOe = 1'b1;
        st_d.pinO = ~pwmLvl ^ st_q.cfg.invert;
      end
    endcase
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= ST_RST;
    end else if (clkEn) begin
      st_q <= st_d;
    end
  end

  assign pinO = st_q.pinO;
  assign pinOe = st_q.pinOe;
  assign outputOn = st_q.outOn;
  assign levelIn = st_q.levelIn;
  assign syncRx = st_q.syncRx;

  // ***************************************************************
  // Checks
  // ***************************************************************
  assign lvlOne = clkEn && (st_q.cfg.mode == MODE_LEVEL) && st_q.cfg.level;
  assign lvlZero = clkEn && (st_q.cfg.mode == MODE_LEVEL) && !st_q.cfg.level;
  assign pwmRun = clkEn && (st_q.cfg.mode == MODE_PWM);
  assign inRun = clkEn && (st_q.cfg.mode == MODE_INPUT);
  assign txTrig = clkEn && isSync && offEdge && (st_q.sm != SY_TX);
  assign hitOn = clkEn && rxHit && st_q.outOn;
  assign hitOff = clkEn && rxHit && !st_q.outOn && !onReq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  AST_INV_RX: assert property (
    $past(clkEn) && !$past(sys_rst) |->
      levelIn == ($past(st_q.stable) ^ $past(st_q.cfg.invert)))
    else $error("level input not inverted as set");

  AST_LVL_ONE: assert property (
    $past(lvlOne) && !$past(sys_rst) |->
      pinOe && (pinO == $past(st_q.cfg.invert)))
    else $error("level one drives wrong pin level");

  AST_LVL_ZERO: assert property (
    $past(lvlZero) && !$past(sys_rst) |->
      pinOe && (pinO == !$past(st_q.cfg.invert)))
    else $error("level zero drives wrong pin level");

  AST_PWM_DRIVE: assert property (
    $past(pwmRun) && !$past(sys_rst) |->
      pinOe && (pinO == ($past(pwmLvl) ~^ $past(st_q.cfg.invert))))
    else $error("pwm pin level does not follow counter");

  AST_IN_FLOAT: assert property (
    $past(inRun) && !$past(sys_rst) |-> !pinOe)
    else $error("pin driven in input function");

  AST_DEF_MODE: assert property (
    $past(sys_rst) |->
      (st_q.cfg.mode == MODE_SYNC) && !st_q.cfg.invert && !pinOe)
    else $error("reset does not select sync turn-off");

  AST_TX_START: assert property (
    $past(txTrig) && !$past(sys_rst) |->
      (st_q.sm == SY_TX) && pinOe && (st_q.txCnt == TX_LAST) &&
      !outputOn)
    else $error("turn-off did not start a pulse");

  AST_RX_KEEP: assert property (
    $past(hitOff) && !$past(sys_rst) |-> !outputOn)
    else $error("pulse while off changed output");

  AST_RX_OFF: assert property (
    $past(hitOn) && !$past(sys_rst) |-> !outputOn ##0 (st_q.sm == SY_TX))
    else $error("pulse while on did not turn off");

  AST_TX_WIDTH: assert property (
    $rose(st_q.sm == SY_TX) |->
      (st_q.txCnt == TX_LAST) && (TX_LAST >= RX_LAST))
    else $error("emitted pulse shorter than minimum");

  // A config write may change polarity mid-pulse, so it is left out
  AST_TX_HOLD: assert property (
    clkEn && isSync && (st_q.sm == SY_TX) && (st_q.txCnt != CNT_ZERO) &&
      !cfgWr |=> pinOe && (pinO == st_q.cfg.invert))
    else $error("pulse level not held");

  AST_TX_END: assert property (
    clkEn && isSync && (st_q.sm == SY_TX) && (st_q.txCnt == CNT_ZERO) &&
      !offEdge && !cfgWr |=> (st_q.sm == SY_WAIT) && !pinOe)
    else $error("pulse did not release the line");

  AST_PARTNER: assert property (
    $past(hitOn) && !$past(sys_rst) |-> syncRx ##1 1'b1)
    else $error("accepted pulse not flagged");

  AST_NO_ECHO: assert property (
    clkEn && isSync && (st_q.sm == SY_WAIT) && rxActive && !offEdge &&
      !cfgWr |=> (st_q.sm == SY_WAIT) && !syncRx)
    else $error("own pulse accepted");

  AST_RX_PULSE: assert property (
    syncRx && clkEn |=> !syncRx)
    else $error("accept flag longer than one cycle");

  AST_RX_SHORT: assert property (
    clkEn && isSync && (st_q.sm == SY_IDLE) && !rxActive |=>
      (st_q.rxCnt == CNT_ZERO))
    else $error("width count not restarted on inactive line");

  AST_SYNC_IDLE: assert property (
    clkEn && isSync && (st_q.sm == SY_WAIT) && !rxActive && !offEdge &&
      !cfgWr |=> !pinOe && (pinO == !st_q.cfg.invert))
    else $error("sync line not released after pulse");

  AST_PWM_WRAP: assert property (
    clkEn && (st_q.cfg.mode == MODE_PWM) && !cfgWr &&
      (st_q.cfg.pwmPeriod != PWM_ZERO) &&
      (st_q.pwmCnt >= st_q.cfg.pwmPeriod - PWM_ONE) |=>
      (st_q.pwmCnt == PWM_ZERO))
    else $error("pwm counter did not wrap at period");

  // Frozen enable keeps config and all counts
  AST_FREEZE: assert property (
    !clkEn |=> $stable(st_q))
    else $error("state changed while clock enable low");

  AST_RX_ONCE: assert property (
    syncRx && $past(clkEn) |->
      ($past(st_q.sm) == SY_IDLE) && (st_q.sm != SY_IDLE))
    else $error("pulse accepted outside idle");

endmodule // sop_sync_off_io_pin
`default_nettype wire

// ==== tb/sop_far_pin.sv ====
`timescale 1ns/1ps
`default_nettype none
module sop_far_pin (
  input wire logic clk,
  input wire logic pinLvl,
  output var logic partOe,
  output var logic partO,
  output var int lastW
);
  int lowCnt;
  initial begin
    partOe = 1'b0;
    partO = 1'b1;
    lastW = 0;
    lowCnt = 0;
  end
  always @(posedge clk) begin
    if (!partOe && !pinLvl) begin
      lowCnt <= lowCnt + 1;
    end else begin
      if (lowCnt != 0) begin
        lastW <= lowCnt;
      end
      lowCnt <= 0;
    end
  end
  task automatic sendPulse(input int n);
    @(posedge clk);
    #1 partO = 1'b0;
    partOe = 1'b1;
    repeat (n) @(posedge clk);
    #1 partOe = 1'b0;
  endtask
  // Released line falls back to the pull-up
  task automatic hold(input logic v);
    partO = v;
    partOe = 1'b1;
  endtask
  task automatic free();
    partOe = 1'b0;
  endtask
endmodule // sop_far_pin
`default_nettype wire

// ==== tb/sop_sync_off_io_pin_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module sop_sync_off_io_pin_tb_top;
  import sop_pkg::*;
  logic clk, sysRst, cfgWr, onReq, offReq, clkEn;
  logic pinO, pinOe, outputOn, levelIn, syncRx, partOe, partO, pinLvl;
  sop_cfg_t cfgIn;
  int lastW, errorCnt, nCompared, rxSeen;

  // Pull-up holds the line idle when nobody drives
  assign pinLvl = pinOe ? pinO : (partOe ? partO : 1'b1);

  sop_sync_off_io_pin u_dut (.clk(clk), .sys_rst(sysRst), .clkEn(clkEn),
    .cfgWr(cfgWr), .cfgIn(cfgIn), .onReq(onReq), .offReq(offReq),
    .pinI(pinLvl), .pinO(pinO), .pinOe(pinOe), .outputOn(outputOn),
    .levelIn(levelIn), .syncRx(syncRx));
  sop_far_pin u_far (.clk(clk), .pinLvl(pinLvl), .partOe(partOe),
    .partO(partO), .lastW(lastW));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (syncRx === 1'b1) begin
      rxSeen <= rxSeen + 1;
    end
  end

  // ***************************************************************
  // Tasks
  // ***************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errorCnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic setCfg(input sop_mode_t m, input logic inv,
                        input logic lv, input logic [15:0] hi);
    cfgIn = '{mode: m, invert: inv, level: lv, pwmPeriod: 16'h000a,
              pwmHigh: hi};
    cfgWr = 1'b1;
    cyc(1);
    cfgWr = 1'b0;
    cyc(2);
  endtask
  task automatic req(input logic on);
    onReq = on;
    offReq = !on;
    cyc(1);
    onReq = 1'b0;
    offReq = 1'b0;
    cyc(1);
  endtask
  task automatic endSim();
    $display("compared %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ***************************************************************
  // Tests
  // ***************************************************************
  initial begin
    #2000000;
    errorCnt++;
    endSim();
  end
  initial begin
    int n;
    sysRst = 1'b1;
    clkEn = 1'b1;
    cfgWr = 1'b0;
    onReq = 1'b0;
    offReq = 1'b0;
    cfgIn = CFG_RST;
    errorCnt = 0;
    nCompared = 0;
    rxSeen = 0;
    cyc(5);
    chk(pinOe, 1'b0);
    chk(levelIn, 1'b1);
    sysRst = 1'b0;
    req(1'b1);
    chk(outputOn, 1'b1);
    req(1'b0);
    chk(pinOe, 1'b1);
    chk(pinO, 1'b0);
    cyc(420);
    chk(16'(lastW), 16'(TX_CYC));
    chk(16'(rxSeen), 16'h0000);
    u_far.sendPulse(350);
    cyc(10);
    chk(16'(rxSeen), 16'h0001);
    chk(outputOn, 1'b0);
    req(1'b1);
    u_far.sendPulse(290);
    cyc(10);
    chk(outputOn, 1'b1);
    chk(16'(rxSeen), 16'h0001);
    u_far.sendPulse(320);
    cyc(10);
    chk(outputOn, 1'b0);
    chk(16'(rxSeen), 16'h0002);
    chk(pinOe, 1'b1);
    cyc(420);
    for (int i = 0; i < 4; i++) begin
      setCfg(MODE_LEVEL, i[1], i[0], 16'h0003);
      chk(pinOe, 1'b1);
      chk(pinO, !i[0] ^ i[1]);
    end
    // Frozen clock enable must drop a config write
    clkEn = 1'b0;
    cfgIn.level = 1'b0;
    cfgWr = 1'b1;
    cyc(3);
    cfgWr = 1'b0;
    clkEn = 1'b1;
    cyc(2);
    chk(pinO, 1'b1);
    for (int i = 0; i < 4; i++) begin
      setCfg(MODE_INPUT, i[1], 1'b0, 16'h0003);
      u_far.hold(i[0]);
      cyc(6);
      chk(pinOe, 1'b0);
      chk(levelIn, i[0] ^ i[1]);
    end
    u_far.free();
    for (int i = 0; i < 2; i++) begin
      setCfg(MODE_PWM, i[0], 1'b0, 16'(3 + 4 * i));
      n = 0;
      repeat (100) begin
        cyc(1);
        if (pinO === i[0]) begin
          n++;
        end
      end
      chk(16'(n), 16'(30 + 40 * i));
    end
    // Second reset must bring back the sync function
    sysRst = 1'b1;
    cyc(2);
    sysRst = 1'b0;
    cyc(1);
    chk(pinOe, 1'b0);
    req(1'b1);
    req(1'b0);
    chk(pinOe, 1'b1);
    endSim();
  end
endmodule // sop_sync_off_io_pin_tb_top
`default_nettype wire
